// ### media_select_rx_address_filter.sv
// Media port selection, receive address filter and duplex control behind AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module media_select_rx_address_filter #(
    parameter int FLP_INTERVAL = media_filter_pkg::FLP_INTERVAL_CYCLES
) (
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic      [31:0]                 hrdata,
    output logic                             ee_req,
    output logic      [5:0]                  ee_addr,
    input  wire media_filter_pkg::word_msg_t ee_reply,
    output logic                             flp_burst,
    output logic      [15:0]                 flp_word,
    input  wire media_filter_pkg::word_msg_t partner_page,
    input  wire logic                        link_present,
    input  wire logic                        carrier_seen,
    output logic                             link_pulse_check_on,
    output logic      [3:0]                  port_choice,
    input  wire media_filter_pkg::rx_byte_t  rx_in,
    output media_filter_pkg::verdict_t       rx_verdict,
    output logic                             receiver_reset_cmd,
    output logic                             transmitter_reset_cmd,
    output logic                             rx_running,
    output logic                             tx_running,
    output logic                             full_duplex,
    input  wire logic                        tx_request,
    input  wire logic                        rx_active,
    input  wire logic                        tx_active,
    input  wire logic                        collision,
    output logic                             tx_go,
    output logic                             collision_backoff
);
    import media_filter_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave.
    logic [31:0]  board_config_word;
    logic [15:0]  installed_ports;
    logic [4:0]   accept_filter;
    logic [47:0]  own_unicast_addr;
    logic         two_way_enable;
    logic [15:0]  advert_reg;
    logic [15:0]  partner_ability_reg;
    logic         negotiation_done;
    logic         d_write;
    logic         d_read;
    logic [7:0]   d_addr;
    logic         wr_en;
    logic [4:0]   cmd_op;
    logic [10:0]  cmd_arg;
    logic         cmd_en;

    // Zero wait states, so the slave never stalls and always answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase is captured; only whole-word transfers are expected.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d_write <= 1'b0;
            d_read  <= 1'b0;
            d_addr  <= 8'h00;
        end else if (hready) begin
            d_write <= hsel && htrans[1] && hwrite;
            d_read  <= hsel && htrans[1] && !hwrite;
            d_addr  <= {haddr[7:2], 2'b00};
        end
    end

    assign wr_en   = d_write;
    assign cmd_en  = wr_en && (d_addr == OFS_COMMAND);
    assign cmd_op  = hwdata[CMD_LSB +: 5];
    assign cmd_arg = hwdata[10:0];

    // Read mux of register state and the live line inputs; a read right after a write sees the new value.
    always_comb begin
        hrdata = 32'h0000_0000;
        if (!d_read) begin
            hrdata = 32'h0000_0000;
        end else if (d_addr == OFS_CONFIG) begin
            hrdata = board_config_word;
        end else if (d_addr == OFS_PORTS) begin
            hrdata = {16'h0000, installed_ports};
        end else if (d_addr == OFS_FILTER) begin
            hrdata = {27'h0, accept_filter};
        end else if (d_addr == OFS_ADDR_LO) begin
            hrdata = own_unicast_addr[31:0];
        end else if (d_addr == OFS_ADDR_HI) begin
            hrdata = {16'h0000, own_unicast_addr[47:32]};
        end else if (d_addr == OFS_MAC) begin
            hrdata = {31'h0, two_way_enable};
        end else if (d_addr == OFS_LINE) begin
            hrdata = {28'h0, full_duplex, carrier_seen, link_present, link_pulse_check_on};
        end else if (d_addr == OFS_PHY_STAT) begin
            hrdata = {26'h0, negotiation_done, 5'h00};
        end else if (d_addr == OFS_ADVERT) begin
            hrdata = {16'h0000, advert_reg};
        end else if (d_addr == OFS_PARTNER) begin
            hrdata = {16'h0000, partner_ability_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // EEPROM load after reset.
    load_state_t ld_state;
    logic [2:0]  ld_idx;
    logic        ld_take;

    assign ee_req  = (ld_state == LD_WAIT);
    assign ld_take = ee_req && ee_reply.valid;

    // Walks station words, config halves and the installed ports word once.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ld_state <= LD_ASK;
            ld_idx   <= 3'd0;
            ee_addr  <= 6'h00;
        end else begin
            case (ld_state)
                LD_ASK: begin
                    if (ld_idx < 3'd3) begin
                        ee_addr <= EE_STATION0 + {4'h0, ld_idx[1:0]};
                    end else if (ld_idx == 3'd3) begin
                        ee_addr <= EE_CONFIG_LO;
                    end else if (ld_idx == 3'd4) begin
                        ee_addr <= EE_CONFIG_HI;
                    end else begin
                        ee_addr <= EE_PORTS;
                    end
                    ld_state <= LD_WAIT;
                end
                LD_WAIT: begin
                    if (ee_reply.valid) begin
                        ld_idx   <= ld_idx + 3'd1;
                        ld_state <= (ld_idx == EE_LAST_IDX) ? LD_DONE : LD_ASK;
                    end
                end
                LD_DONE: begin
                    ld_state <= LD_DONE;
                end
                default: begin
                    ld_state <= LD_DONE;
                end
            endcase
        end
    end

    // Software write to the config word loses to a load in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            board_config_word <= CONFIG_RESET;
        end else if (ld_take && ld_idx == 3'd3) begin
            board_config_word[15:0] <= ee_reply.data;
        end else if (ld_take && ld_idx == 3'd4) begin
            board_config_word[31:16] <= ee_reply.data;
        end else if (wr_en && d_addr == OFS_CONFIG) begin
            board_config_word <= hwdata;
        end
    end

    assign port_choice = board_config_word[PORT_LSB +: 4];

    // Installed ports is read-only to software.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            installed_ports <= 16'h0000;
        end else if (ld_take && ld_idx == EE_LAST_IDX) begin
            installed_ports <= ee_reply.data;
        end
    end

    // Station address, first wire byte in the low bits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            own_unicast_addr <= 48'h0;
        end else if (ld_take && ld_idx < 3'd3) begin
            own_unicast_addr[ld_idx*16 +: 16] <= ee_reply.data;
        end else if (wr_en && d_addr == OFS_ADDR_LO) begin
            own_unicast_addr[31:0] <= hwdata;
        end else if (wr_en && d_addr == OFS_ADDR_HI) begin
            own_unicast_addr[47:32] <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Commands, MAC settings and line state.
    logic [255:0] hash_table;

    // Filter is only loaded by command; plain writes to its offset are ignored.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            accept_filter <= 5'h00;
        end else if (cmd_en && cmd_op == CMD_LOAD_FILT) begin
            accept_filter <= cmd_arg[4:0];
        end
    end

    // One table entry per command: index in the low byte, value above it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hash_table <= 256'h0;
        end else if (cmd_en && cmd_op == CMD_HASH_ENTRY) begin
            hash_table[cmd_arg[7:0]] <= cmd_arg[HASH_VAL_BIT];
        end
    end

    // Reset commands pulse for one cycle and stop the path until re-enabled.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            receiver_reset_cmd    <= 1'b0;
            transmitter_reset_cmd <= 1'b0;
            rx_running            <= 1'b0;
            tx_running            <= 1'b0;
        end else begin
            receiver_reset_cmd    <= cmd_en && cmd_op == CMD_RX_RESET;
            transmitter_reset_cmd <= cmd_en && cmd_op == CMD_TX_RESET;
            if (cmd_en && cmd_op == CMD_RX_RESET) begin
                rx_running <= 1'b0;
            end else if (cmd_en && cmd_op == CMD_RX_ON) begin
                rx_running <= 1'b1;
            end
            if (cmd_en && cmd_op == CMD_TX_RESET) begin
                tx_running <= 1'b0;
            end else if (cmd_en && cmd_op == CMD_TX_ON) begin
                tx_running <= 1'b1;
            end
        end
    end

    // Software-owned settings.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            two_way_enable      <= 1'b0;
            link_pulse_check_on <= 1'b0;
            advert_reg          <= ADVERT_RESET;
        end else if (wr_en) begin
            if (d_addr == OFS_MAC) begin
                two_way_enable <= hwdata[TWO_WAY_BIT];
            end
            if (d_addr == OFS_LINE) begin
                link_pulse_check_on <= hwdata[PULSE_CHK_BIT];
            end
            if (d_addr == OFS_ADVERT) begin
                advert_reg <= hwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auto-negotiation: starts on its own and repeats bursts at a fixed spacing.
    logic [31:0] an_count;
    logic        an_started;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            an_count   <= 32'h0;
            an_started <= 1'b0;
            flp_burst  <= 1'b0;
            flp_word   <= 16'h0000;
        end else begin
            flp_burst <= 1'b0;
            if (!an_started && an_count == 32'(AN_START_CYCLES - 1)) begin
                an_started <= 1'b1;
                an_count   <= 32'h0;
                flp_burst  <= 1'b1;
                flp_word   <= advert_reg;
            end else if (an_started && an_count == 32'(FLP_INTERVAL - 1)) begin
                an_count  <= 32'h0;
                flp_burst <= 1'b1;
                flp_word  <= advert_reg;
            end else begin
                an_count <= an_count + 32'h1;
            end
        end
    end

    // A partner page is only heard once bursts have begun.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            partner_ability_reg <= 16'h0000;
            negotiation_done    <= 1'b0;
        end else if (an_started && partner_page.valid) begin
            partner_ability_reg <= partner_page.data;
            negotiation_done    <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive address filter, decided on the sixth destination byte.
    logic [2:0]  byte_cnt;
    logic [47:0] dest;
    logic [47:0] dest_full;
    logic [31:0] crc_next;
    logic        last_dest;
    logic        hit_own;
    logic        hit_stations;
    logic        is_group;
    logic        hit_hash;

    hash_crc u_hash_crc (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clear    (rx_in.valid && rx_in.sof),
        .step     (rx_in.valid && byte_cnt < 3'd6),
        .byte_in  (rx_in.data),
        .crc_next (crc_next)
    );

    // Byte count restarts on every frame start.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            byte_cnt <= 3'd6;
            dest     <= 48'h0;
        end else if (rx_in.valid && rx_in.sof) begin
            byte_cnt <= 3'd1;
            dest     <= {40'h0, rx_in.data};
        end else if (rx_in.valid && byte_cnt < 3'd6) begin
            byte_cnt                <= byte_cnt + 3'd1;
            dest[byte_cnt*8 +: 8]   <= rx_in.data;
        end
    end

    assign last_dest    = rx_in.valid && !rx_in.sof && byte_cnt == 3'd5;
    assign dest_full    = {rx_in.data, dest[39:0]};
    assign hit_own      = accept_filter[F_OWN] && dest_full == own_unicast_addr;
    assign hit_stations = accept_filter[F_STATIONS] && (&dest_full);
    assign is_group     = dest_full[0];
    assign hit_hash     = accept_filter[F_HASHED] && hash_table[crc_next[7:0]];

    // Verdict pulse one cycle after the last destination byte.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_verdict <= '0;
        end else begin
            rx_verdict.valid  <= last_dest && rx_running;
            rx_verdict.accept <= accept_filter[F_EVERYTHING]
                              || hit_own
                              || hit_stations
                              || (is_group && accept_filter[F_GROUPS])
                              || (is_group && hit_hash);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Duplex: the two-way bit decides in every port choice; software sets it.
    assign full_duplex = two_way_enable;

    // Half duplex defers to carrier and reception; full duplex ignores both.
    assign tx_go = tx_running && tx_request
                && (full_duplex || (!carrier_seen && !rx_active));
    assign collision_backoff = !full_duplex && tx_active && collision;

endmodule : media_select_rx_address_filter
`default_nettype wire

// ### media_filter_pkg.sv
// Constants, types and register map of the media select and receive filter block.
package media_filter_pkg;

    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] OFS_CONFIG   = 8'h00;
    localparam logic [7:0] OFS_PORTS    = 8'h04;
    localparam logic [7:0] OFS_COMMAND  = 8'h08;
    localparam logic [7:0] OFS_FILTER   = 8'h0c;
    localparam logic [7:0] OFS_ADDR_LO  = 8'h10;
    localparam logic [7:0] OFS_ADDR_HI  = 8'h14;
    localparam logic [7:0] OFS_MAC      = 8'h18;
    localparam logic [7:0] OFS_LINE     = 8'h1c;
    localparam logic [7:0] OFS_PHY_STAT = 8'h20;
    localparam logic [7:0] OFS_ADVERT   = 8'h24;
    localparam logic [7:0] OFS_PARTNER  = 8'h28;

    // Field positions.
    localparam int PORT_LSB       = 20;
    localparam int AUTO_PORT_BIT  = 24;
    localparam int TWO_WAY_BIT    = 0;
    localparam int PULSE_CHK_BIT  = 0;
    localparam int LINK_BIT       = 1;
    localparam int CARRIER_BIT    = 2;
    localparam int DUPLEX_BIT     = 3;
    localparam int NEG_DONE_BIT   = 5;
    localparam int F_OWN          = 0;
    localparam int F_GROUPS       = 1;
    localparam int F_STATIONS     = 2;
    localparam int F_EVERYTHING   = 3;
    localparam int F_HASHED       = 4;
    localparam int CMD_LSB        = 11;
    localparam int HASH_VAL_BIT   = 8;

    // Command codes written to the command register.
    localparam logic [4:0] CMD_RX_RESET   = 5'h01;
    localparam logic [4:0] CMD_TX_RESET   = 5'h02;
    localparam logic [4:0] CMD_RX_ON      = 5'h03;
    localparam logic [4:0] CMD_TX_ON      = 5'h04;
    localparam logic [4:0] CMD_LOAD_FILT  = 5'h05;
    localparam logic [4:0] CMD_HASH_ENTRY = 5'h06;

    // Serial EEPROM word addresses loaded after reset.
    localparam logic [5:0] EE_STATION0  = 6'h00;
    localparam logic [5:0] EE_CONFIG_LO = 6'h0d;
    localparam logic [5:0] EE_CONFIG_HI = 6'h0e;
    localparam logic [5:0] EE_PORTS     = 6'h13;
    localparam logic [2:0] EE_LAST_IDX  = 3'd5;

    // Reset values.
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [15:0] ADVERT_RESET = 16'h01e1;
    localparam logic [3:0]  PORT_AUTONEG = 4'h8;

    // Ethernet frame check polynomial, reflected.
    localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

    // Negotiation timing.
    localparam int CLK_MHZ             = 100;
    localparam int AN_START_US         = 10;
    localparam int AN_START_CYCLES     = AN_START_US * CLK_MHZ;
    localparam int FLP_INTERVAL_US     = 16000;
    localparam int FLP_INTERVAL_CYCLES = FLP_INTERVAL_US * CLK_MHZ;

    typedef struct packed {
        logic       valid;
        logic       sof;
        logic [7:0] data;
    } rx_byte_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } word_msg_t;

    typedef struct packed {
        logic valid;
        logic accept;
    } verdict_t;

    typedef enum logic [2:0] {
        LD_ASK  = 3'b001,
        LD_WAIT = 3'b010,
        LD_DONE = 3'b100
    } load_state_t;

endpackage : media_filter_pkg

// ### hash_crc.sv
// Byte-serial Ethernet CRC used to index the multicast hash table.
`timescale 1ns/1ps
`default_nettype none
module hash_crc (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clear,
    input  wire logic        step,
    input  wire logic [7:0]  byte_in,
    output logic      [31:0] crc_next
);
    import media_filter_pkg::*;

    logic [31:0] crc;
    logic [31:0] seed;

    // A frame start seeds from the initial value instead of the last frame's sum.
    assign seed = clear ? CRC_INIT : crc;

    // Bits enter least significant first, as they leave the wire.
    always_comb begin
        crc_next = seed;
        for (int i = 0; i < 8; i++) begin
            if (crc_next[0] ^ byte_in[i]) begin
                crc_next = (crc_next >> 1) ^ CRC_POLY;
            end else begin
                crc_next = crc_next >> 1;
            end
        end
    end

    // Clear folds the first destination byte into a fresh sum, so all six bytes count.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc <= CRC_INIT;
        end else if (clear || step) begin
            crc <= crc_next;
        end
    end

endmodule : hash_crc
`default_nettype wire

// ### link_partner_model.sv
// Far-side model: serial EEPROM and a negotiating hub.
`timescale 1ns/1ps
`default_nettype none
module link_partner_model #(
    parameter int DELAY = 2
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   ee_req,
    input  wire logic [5:0]             ee_addr,
    output media_filter_pkg::word_msg_t ee_reply,
    input  wire logic                   flp_burst,
    output media_filter_pkg::word_msg_t partner_page
);
    import media_filter_pkg::*;
    int         cnt;
    logic [2:0] dly;
    logic       give;
    assign give = ee_req && !ee_reply.valid && cnt == DELAY;
    ////////////////////
    // Slow reply; idle data lines toggle so no stale word can pass for a good one.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            ee_reply <= '0;
        end else begin
            cnt <= (ee_req && !ee_reply.valid) ? cnt + 1 : 0;
            ee_reply.valid <= give;
            ee_reply.data <= !give ? ~ee_reply.data : ee_addr == 6'h00 ? 16'h3402 :
                ee_addr == 6'h01 ? 16'h7788 : ee_addr == 6'h02 ? 16'h5566 :
                ee_addr == EE_CONFIG_HI ? 16'h0050 : ee_addr == EE_PORTS ? 16'h00a5 : 16'h0;
        end
    end
    // The hub answers each burst with its page four cycles later.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dly <= '0;
            partner_page <= '0;
        end else begin
            dly <= {dly[1:0], flp_burst};
            partner_page <= {dly[2], dly[2] ? 16'h4141 : ~partner_page.data};
        end
    end
endmodule : link_partner_model
`default_nettype wire

// ### rx_filter_monitor.sv
// Port checks for the media select and receive filter block.
`timescale 1ns/1ps
`default_nettype none
module rx_filter_monitor (
    input wire logic hclk, hresetn, ee_req, full_duplex, tx_running, tx_request,
    input wire logic rx_active, carrier_seen, tx_active, collision, tx_go, collision_backoff,
    input wire logic [5:0] ee_addr,
    input wire media_filter_pkg::word_msg_t ee_reply,
    input wire media_filter_pkg::rx_byte_t rx_in,
    input wire media_filter_pkg::verdict_t rx_verdict
);
    import media_filter_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // The loader idles one cycle after each word, then asks for the next.
    sequence s_reask;
        !ee_req ##1 ee_req;
    endsequence
    chk_ee_hold: assert property (ee_req && !ee_reply.valid |=> ee_req && $stable(ee_addr))
        else $error("ee hold");
    chk_ee_reask: assert property (ee_req && ee_reply.valid && ee_addr != EE_PORTS |=> s_reask)
        else $error("ee reask");
    chk_ports_last: assert property (ee_req && ee_reply.valid && ee_addr == EE_CONFIG_HI
        |-> ##2 ee_addr == EE_PORTS) else $error("ee order");
    chk_tx_defer: assert property (!full_duplex && (carrier_seen || rx_active) |-> !tx_go)
        else $error("tx defer");
    chk_hd_backoff: assert property (!full_duplex && tx_active && collision |-> collision_backoff)
        else $error("backoff");
    chk_fd_send: assert property (full_duplex && tx_running && tx_request |-> tx_go)
        else $error("fd send");
    chk_fd_no_coll: assert property (full_duplex |-> !collision_backoff)
        else $error("fd coll");
    chk_verdict_cause: assert property (rx_verdict.valid |-> $past(rx_in.valid)
        && !$past(rx_verdict.valid)) else $error("verdict");
endmodule : rx_filter_monitor
bind media_select_rx_address_filter rx_filter_monitor u_rx_filter_monitor (.*);
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the media select and receive filter block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import media_filter_pkg::*;
    typedef struct packed {logic [4:0] filt; logic [47:0] dest; logic acc;} row_t;
    localparam logic [47:0] GRP = 48'h3322_1100_5e01;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ee_req, flp_burst, link_present;
    logic carrier_seen, link_pulse_check_on, receiver_reset_cmd, transmitter_reset_cmd;
    logic rx_running, tx_running, full_duplex, tx_request, rx_active, tx_active, collision;
    logic tx_go, collision_backoff;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] flp_word;
    logic [5:0] ee_addr;
    logic [3:0] port_choice;
    logic [2:0] hsize;
    logic [1:0] htrans;
    wire logic hready;
    word_msg_t ee_reply, partner_page;
    rx_byte_t rx_in;
    verdict_t rx_verdict;
    int fail_count = 0;
    int compares = 0;
    row_t rows[8] = '{'{5'h01, 48'h5566_7788_3402, 1'b1}, '{5'h01, 48'h5566_7788_3400, 1'b0},
        '{5'h04, 48'hffff_ffff_ffff, 1'b1}, '{5'h01, 48'hffff_ffff_ffff, 1'b0},
        '{5'h02, GRP, 1'b1}, '{5'h08, 48'h0000_0000_0a00, 1'b1},
        '{5'h10, GRP, 1'b1}, '{5'h10, 48'h0000_0000_0003, 1'b0}};
    assign hready = hreadyout;
    media_select_rx_address_filter #(.FLP_INTERVAL(50)) u_media_select_rx_address_filter (.*);
    link_partner_model u_link_partner_model (.*);
    ////////////////////
    // Clock at 100 MHz.
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Hash index formed independently: reflected CRC, bit 0 of byte 0 first.
    function automatic logic [7:0] hash_idx(input logic [47:0] d);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 48; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? CRC_POLY : 32'h0);
        return c[7:0];
    endfunction : hash_idx
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One AHB single; hrdata is taken at the edge that closes the data phase.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : rchk
    task automatic cmd(input logic [4:0] op, input logic [10:0] arg);
        bus(1'b1, OFS_COMMAND, {16'h0, op, arg});
    endtask : cmd
    // Six destination bytes back to back; the verdict stands one cycle after.
    task automatic frame(input logic [47:0] d, input logic acc);
        for (int i = 0; i < 6; i++) begin
            @(posedge hclk);
            rx_in <= {1'b1, i == 0, d[8*i +: 8]};
        end
        @(posedge hclk);
        rx_in <= '0;
        #1 check("verdict", rx_verdict, {1'b1, acc});
    endtask : frame
    // Reset for two cycles, then wait for the last EEPROM word to land.
    task automatic reset_and_load();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        do @(posedge hclk); while (!(ee_reply.valid && ee_addr === EE_PORTS));
    endtask : reset_and_load
    task automatic final_report();
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    // A run takes about 1,100 cycles, so 20,000 means a hang.
    initial begin
        #200us;
        fail_count++;
        final_report();
    end
    // Loaded values, filter cases, reset commands and line state, duplex, negotiation, then a second reset.
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, rx_in, carrier_seen} = '0;
        {tx_request, rx_active, tx_active, collision, hsize, link_present} = 8'h05;
        hresetn = 1'b0;
        reset_and_load();
        check("port", port_choice, 4'h5);
        rchk("config", OFS_CONFIG, 32'h0050_0000);
        rchk("ports", OFS_PORTS, 32'h0000_00a5);
        rchk("addr", OFS_ADDR_LO, 32'h7788_3402);
        rchk("unmapped", 8'h3c, 32'h0);
        bus(1'b1, OFS_FILTER, 32'h1f);
        rchk("filter", OFS_FILTER, 32'h0);
        cmd(CMD_RX_ON, 11'h0);
        cmd(CMD_HASH_ENTRY, {3'h1, hash_idx(GRP)});
        for (int i = 0; i < 8; i++) begin
            cmd(CMD_LOAD_FILT, {6'h0, rows[i].filt});
            frame(rows[i].dest, rows[i].acc);
        end
        bus(1'b1, OFS_CONFIG, 32'h0050_0000);
        cmd(CMD_RX_RESET, 11'h0);
        #1 check("rx reset", {receiver_reset_cmd, rx_running}, 2'b10);
        cmd(CMD_TX_RESET, 11'h0);
        #1 check("tx reset", transmitter_reset_cmd, 1'b1);
        bus(1'b1, OFS_LINE, 32'h1);
        rchk("line", OFS_LINE, 32'h3);
        cmd(CMD_LOAD_FILT, 11'h8);
        cmd(CMD_RX_ON, 11'h0);
        cmd(CMD_TX_ON, 11'h0);
        frame(48'h5566_7788_3402, 1'b1);
        {tx_request, rx_active, tx_active, collision} <= 4'hf;
        bus(1'b1, OFS_MAC, 32'h1);
        #1 check("fd send", {tx_go, collision_backoff}, 2'b10);
        bus(1'b1, OFS_MAC, 32'h0);
        #1 check("hd send", {tx_go, collision_backoff}, 2'b01);
        do @(posedge hclk); while (flp_burst !== 1'b1);
        #1 check("advert", flp_word, 16'h01e1);
        repeat (4) @(posedge hclk);
        rchk("partner", OFS_PARTNER, 32'h4141);
        rchk("neg done", OFS_PHY_STAT, 32'h20);
        bus(1'b1, OFS_ADDR_HI, 32'h1234);
        rchk("addr hi", OFS_ADDR_HI, 32'h1234);
        reset_and_load();
        rchk("filter", OFS_FILTER, 32'h0);
        check("rx off", rx_running, 1'b0);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
